// ===== src/mxs_pkg.sv
// Constants for the serial-controlled five-mux switch slave.
// Assumes one 100 MHz system clock that oversamples the serial bus pins.
// Function
// - Slave only, never drives serial clock.
// - Start condition re-arms receiver for address.
// - Shift seven address bits MSB first, direction.
// - Acknowledge matching address on ninth pulse.
// - Unmatched device idles until next start.
// - Direction one reads, zero writes.
// - Each byte is eight bits plus acknowledge.
// - Data rising while clock high is stop.
// - Stop condition returns device to idle.
// - Address is 1010 plus three strap bits.
// - Write takes command byte then mode byte.
// - Bit 7 value; selectors 0,1 act group-wide.
// - Selectors 14..18 disable muxes 1..5.
// - Selector 20 sets general output from bit 7.
// - Code 1F disables all; listed codes reserved.
// - Later command on same element wins.
// - Commands pend until staged-load bit applies them.
// - Reset or soft reset opens all, output low.
// - Read returns two status bytes with acknowledge.
// - Readback bits 15..6 switches, bit 3 output.
package mxs_pkg;
  localparam logic [3:0] ADDR_FIXED = 4'hA;
  localparam int MUX_COUNT = 5;
  localparam int SW_COUNT = 10;
  localparam logic [6:0] SEL_ALL_A = 7'h00;
  localparam logic [6:0] SEL_ALL_B = 7'h01;
  localparam logic [6:0] SEL_SW_FIRST = 7'h02;
  localparam logic [6:0] SEL_SW_LAST = 7'h0B;
  localparam logic [6:0] SEL_DIS_FIRST = 7'h0E;
  localparam logic [6:0] SEL_DIS_LAST = 7'h12;
  localparam logic [6:0] SEL_GPO = 7'h14;
  localparam logic [7:0] CMD_DIS_ALL = 8'h1F;
  localparam int LOAD_BIT_POS = 1;
  localparam int RESET_N_BIT_POS = 0;
  localparam logic [9:0] SW_RESET = 10'h000;
  localparam logic GPO_RESET = 1'b0;
  localparam int RB_SW_LSB = 6;
  localparam int RB_GPO_POS = 3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_WR = 3'b010,
    ST_RD = 3'b011,
    ST_RDACK = 3'b100
  } mxs_state_e;
endpackage

// ===== src/mxs_switch_slave.sv
// Serial bus slave that drives five 2:1 mux switch enables and one output.
// Assumes bus and strap pins come from another domain; all sampled by ref_clk.
module mxs_switch_slave #(
  parameter bit HAS_GPO = 1'b1
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  input wire logic addr_strap_0,
  input wire logic addr_strap_1,
  input wire logic addr_strap_2,
  output logic [9:0] switchClosed,
  output logic general_output_pin
);
  // Switch bit order: index 9 is mux1 A, index 0 is mux5 B
  // The switch image layout only works with two switches per mux
  if (mxs_pkg::SW_COUNT != 2 * mxs_pkg::MUX_COUNT) begin : g_bad_layout
    $error("Switch count must be twice the mux count");
  end

  // Two-flop synchronisers, then a history stage for edge detection
  logic [1:0] sclSync_q, sdaSync_q;
  logic sclPrev_q, sdaPrev_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sclSync_q <= 2'b11;
      sdaSync_q <= 2'b11;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclSync_q <= {sclSync_q[0], sclIn};
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      sclPrev_q <= sclSync_q[1];
      sdaPrev_q <= sdaSync_q[1];
    end
  end

  // Straps are pins as well; they settle long before an address byte completes
  logic [2:0] strapSync0_q, strapSync1_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      strapSync0_q <= 3'h0;
      strapSync1_q <= 3'h0;
    end else begin
      strapSync0_q <= {addr_strap_2, addr_strap_1, addr_strap_0};
      strapSync1_q <= strapSync0_q;
    end
  end

  logic scl, sda, sclRise, sclFall, startSeen, stopSeen;
  assign scl = sclSync_q[1];
  assign sda = sdaSync_q[1];
  assign sclRise = scl && !sclPrev_q;
  assign sclFall = !scl && sclPrev_q;
  assign startSeen = scl && sclPrev_q && sdaPrev_q && !sda;
  assign stopSeen = scl && sclPrev_q && !sdaPrev_q && sda;

  // Apply one command to a switch/output image; later calls override earlier
  function automatic logic [10:0] apply_cmd(input logic [10:0] img, input logic [7:0] cmd);
    logic [10:0] r;
    logic [6:0] sel;
    r = img;
    sel = cmd[6:0];
    if (sel == mxs_pkg::SEL_ALL_A) begin
      for (int m = 0; m < mxs_pkg::MUX_COUNT; m++) r[9 - 2 * m] = cmd[7];
    end else if (sel == mxs_pkg::SEL_ALL_B) begin
      for (int m = 0; m < mxs_pkg::MUX_COUNT; m++) r[8 - 2 * m] = cmd[7];
    end else if (sel >= mxs_pkg::SEL_SW_FIRST && sel <= mxs_pkg::SEL_SW_LAST) begin
      r[4'(11 - sel)] = cmd[7];
    end else if (sel >= mxs_pkg::SEL_DIS_FIRST && sel <= mxs_pkg::SEL_DIS_LAST) begin
      r[4'(9 - 2 * (sel - mxs_pkg::SEL_DIS_FIRST))] = 1'b0;
      r[4'(8 - 2 * (sel - mxs_pkg::SEL_DIS_FIRST))] = 1'b0;
    end else if (sel == mxs_pkg::SEL_GPO && HAS_GPO) begin
      r[10] = cmd[7];
    end else if (cmd == mxs_pkg::CMD_DIS_ALL) begin
      r[9:0] = 10'h000;
    end
    // Anything else is reserved and leaves the image alone
    return r;
  endfunction

  // Bus protocol state
  mxs_pkg::mxs_state_e state_q, state_d;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] cmdByte_q, cmdByte_d;
  logic byteIdx_q, byteIdx_d;
  logic ackPend_q, ackPend_d;
  logic drvLow_q, drvLow_d;
  logic oeN_q, oeN_d;
  logic [15:0] rdWord_q, rdWord_d;
  logic [10:0] pend_q, pend_d;
  logic [9:0] sw_q, sw_d;
  logic gpo_q, gpo_d;
  logic [6:0] ownAddr;
  logic [10:0] merged;
  assign ownAddr = {mxs_pkg::ADDR_FIXED, strapSync1_q};
  assign merged = apply_cmd(pend_q, cmdByte_q);

  // Next-state logic: bits taken on scl rise, sda changed on scl fall
  always_comb begin
    state_d = state_q;
    bitCnt_d = bitCnt_q;
    shift_d = shift_q;
    cmdByte_d = cmdByte_q;
    byteIdx_d = byteIdx_q;
    ackPend_d = ackPend_q;
    drvLow_d = drvLow_q;
    rdWord_d = rdWord_q;
    pend_d = pend_q;
    sw_d = sw_q;
    gpo_d = gpo_q;
    if (startSeen) begin
      state_d = mxs_pkg::ST_ADDR;
      bitCnt_d = 4'h0;
      drvLow_d = 1'b0;
      ackPend_d = 1'b0;
    end else if (stopSeen) begin
      state_d = mxs_pkg::ST_IDLE;
      drvLow_d = 1'b0;
    end else if (state_q != mxs_pkg::ST_IDLE) begin
      if (sclRise) begin
        if (bitCnt_q < 4'h8) begin
          shift_d = {shift_q[6:0], sda};
          bitCnt_d = bitCnt_q + 4'h1;
        end else begin
          bitCnt_d = 4'h0; // Ninth pulse closes the byte
          if (state_q == mxs_pkg::ST_RDACK && sda) begin
            state_d = mxs_pkg::ST_IDLE;
          end
        end
      end else if (sclFall) begin
        drvLow_d = 1'b0;
        if (bitCnt_q == 4'h8) begin
          unique case (state_q)
            mxs_pkg::ST_ADDR: begin
              if (shift_q[7:1] == ownAddr) begin
                drvLow_d = 1'b1;
                byteIdx_d = 1'b0;
                ackPend_d = shift_q[0];
                state_d = shift_q[0] ? mxs_pkg::ST_RDACK : mxs_pkg::ST_WR;
                rdWord_d = {sw_q, 2'b00, gpo_q, 3'b000};
              end else begin
                state_d = mxs_pkg::ST_IDLE;
              end
            end
            mxs_pkg::ST_WR: begin
              drvLow_d = 1'b1;
              byteIdx_d = ~byteIdx_q;
              if (!byteIdx_q) begin
                cmdByte_d = shift_q;
              end else begin
                pend_d = merged;
                if (!shift_q[mxs_pkg::RESET_N_BIT_POS]) begin
                  pend_d = {mxs_pkg::GPO_RESET, mxs_pkg::SW_RESET};
                  sw_d = mxs_pkg::SW_RESET;
                  gpo_d = mxs_pkg::GPO_RESET;
                end else if (shift_q[mxs_pkg::LOAD_BIT_POS]) begin
                  sw_d = merged[9:0];
                  gpo_d = merged[10];
                end
              end
            end
            mxs_pkg::ST_RD: begin
              state_d = mxs_pkg::ST_RDACK; // Release for master acknowledge
            end
            mxs_pkg::ST_RDACK: begin
              state_d = mxs_pkg::ST_RD;
            end
            default: begin
              state_d = mxs_pkg::ST_IDLE;
            end
          endcase
        end else if (state_q == mxs_pkg::ST_RDACK && bitCnt_q == 4'h0) begin
          // First data bit after the address or a master acknowledge
          state_d = mxs_pkg::ST_RD;
          // After a master acknowledge the byte index flips at this same fall, so choose by its next value
          drvLow_d = !((byteIdx_q ^ !ackPend_q) ? rdWord_q[7] : rdWord_q[15]);
          if (!ackPend_q) byteIdx_d = ~byteIdx_q;
          ackPend_d = 1'b0;
        end else if (state_q == mxs_pkg::ST_RD && bitCnt_q < 4'h8) begin
          drvLow_d = !(byteIdx_q ? rdWord_q[4'(7 - bitCnt_q)] : rdWord_q[4'(15 - bitCnt_q)]);
        end
      end
    end
    // Active-low enable kept in its own flop so the pin comes straight from a register
    oeN_d = ~drvLow_d;
  end

  // Reset puts every switch open and the output low
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= mxs_pkg::ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      cmdByte_q <= 8'h00;
      byteIdx_q <= 1'b0;
      ackPend_q <= 1'b0;
      drvLow_q <= 1'b0;
      oeN_q <= 1'b1;
      rdWord_q <= 16'h0000;
      pend_q <= {mxs_pkg::GPO_RESET, mxs_pkg::SW_RESET};
      sw_q <= mxs_pkg::SW_RESET;
      gpo_q <= mxs_pkg::GPO_RESET;
    end else begin
      state_q <= state_d;
      bitCnt_q <= bitCnt_d;
      shift_q <= shift_d;
      cmdByte_q <= cmdByte_d;
      byteIdx_q <= byteIdx_d;
      ackPend_q <= ackPend_d;
      drvLow_q <= drvLow_d;
      oeN_q <= oeN_d;
      rdWord_q <= rdWord_d;
      pend_q <= pend_d;
      sw_q <= sw_d;
      gpo_q <= gpo_d;
    end
  end

  // Open-drain data: only ever pulls low; there is no clock output at all
  assign sdaOut = 1'b0;
  assign sdaOe_n = oeN_q;
  assign switchClosed = sw_q;
  assign general_output_pin = gpo_q;

  // Falling scl that ends the eighth bit of a byte, with no start or stop beside it
  sequence s_byte_end;
    sclFall && bitCnt_q == 4'h8 && !startSeen && !stopSeen;
  endsequence

  // Falling scl that ends the acknowledge pulse
  sequence s_ack_end;
    sclFall && bitCnt_q == 4'h0 && !startSeen && !stopSeen;
  endsequence

  property p_ack_match;
    @(posedge ref_clk) disable iff (!nrst)
      s_byte_end ##0 (state_q == mxs_pkg::ST_ADDR && shift_q[7:1] == ownAddr) |=> !sdaOe_n;
  endproperty
  a_ack_match: assert property (p_ack_match)
    else $error("No ack on own address");

  property p_nomatch_idle;
    @(posedge ref_clk) disable iff (!nrst)
      s_byte_end ##0 (state_q == mxs_pkg::ST_ADDR && shift_q[7:1] != ownAddr)
      |=> (state_q == mxs_pkg::ST_IDLE && sdaOe_n);
  endproperty
  a_nomatch_idle: assert property (p_nomatch_idle)
    else $error("Drove bus on foreign address");

  property p_stop_idle;
    @(posedge ref_clk) disable iff (!nrst) stopSeen |=> (state_q == mxs_pkg::ST_IDLE && sdaOe_n);
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("Stop did not idle");

  property p_start_rearm;
    @(posedge ref_clk) disable iff (!nrst)
      startSeen |=> (state_q == mxs_pkg::ST_ADDR && bitCnt_q == 4'h0);
  endproperty
  a_start_rearm: assert property (p_start_rearm)
    else $error("Start did not re-arm");

  // Both sides of one mux closed means a bad command stream or a mis-mapped selector
  property p_never_both;
    @(posedge ref_clk) disable iff (!nrst)
      (sdaOut == 1'b0) && ((sw_q & (sw_q >> 1) & 10'h155) == 10'h000);
  endproperty
  a_never_both: assert property (p_never_both)
    else $error("Data pin driven high or both sides of a mux closed");

  property p_sw_stable;
    @(posedge ref_clk) disable iff (!nrst)
      (state_q != mxs_pkg::ST_WR) |=> $stable(sw_q);
  endproperty
  a_sw_stable: assert property (p_sw_stable)
    else $error("Switches moved outside write");

  property p_gpo_stable;
    @(posedge ref_clk) disable iff (!nrst)
      (state_q != mxs_pkg::ST_WR) |=> $stable(gpo_q);
  endproperty
  a_gpo_stable: assert property (p_gpo_stable)
    else $error("Output moved outside write");

  property p_idle_quiet;
    @(posedge ref_clk) disable iff (!nrst)
      (state_q == mxs_pkg::ST_IDLE && !startSeen) ##1 (state_q == mxs_pkg::ST_IDLE) |-> sdaOe_n;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("Idle but driving data");

  property p_wr_ack;
    @(posedge ref_clk) disable iff (!nrst)
      s_byte_end ##0 (state_q == mxs_pkg::ST_WR) |=> !sdaOe_n;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("Write byte not acknowledged");

  // The ack must not overlap the next data bit, or the master would see a false zero
  property p_ack_release;
    @(posedge ref_clk) disable iff (!nrst)
      s_ack_end ##0 (state_q == mxs_pkg::ST_WR) |=> sdaOe_n;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("Ack held past its pulse");

  property p_soft_reset;
    @(posedge ref_clk) disable iff (!nrst)
      s_byte_end ##0 (state_q == mxs_pkg::ST_WR && byteIdx_q && !shift_q[mxs_pkg::RESET_N_BIT_POS])
      |=> (sw_q == mxs_pkg::SW_RESET && gpo_q == mxs_pkg::GPO_RESET);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("Soft reset not applied");
endmodule

// ===== verification/mxs_master.sv
// Serial bus master model: drives the link clock and releases or pulls data.
// Assumes a pull-up on data; the bench merges both parties' drives.
module mxs_master (
  input wire logic ref_clk,
  input wire logic sdaBus,
  output logic sclOut,
  output logic sdaRel
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock stands high and data is released between frames
  initial begin
    sclOut = 1'b1;
    sdaRel = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Four ref_clk cycles per half, an 80 ns link period; sampled late in high
  task automatic bitx(input logic b, output logic r);
    wt(2);
    sdaRel <= b;
    wt(2);
    sclOut <= 1'b1;
    wt(3);
    @(negedge ref_clk) r = sdaBus;
    @(posedge ref_clk) sclOut <= 1'b0;
  endtask
  task automatic start();
    sdaRel <= 1'b0;
    wt(2);
    sclOut <= 1'b0;
  endtask
  task automatic stop();
    wt(2);
    sdaRel <= 1'b0;
    wt(2);
    sclOut <= 1'b1;
    wt(2);
    sdaRel <= 1'b1;
    wt(6);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  // Last byte of a read is left unacknowledged
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);
  endtask
endmodule

// ===== verification/mxs_switch_slave_tb_top.sv
// Bench for the mux switch slave: command table, then hand-written cases.
// Assumes the master model owns the link clock; sda has a pull-up.
module mxs_switch_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic refClk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] strap = 3'h5;
  logic sclW, sdaRel, sdaOut, sdaOe_n, gpo, ack;
  logic [9:0] sw;
  logic [7:0] hi, lo;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  wire sdaBus = sdaRel & (sdaOe_n | sdaOut);
  wire [6:0] dev = {mxs_pkg::ADDR_FIXED, strap};
  // Command, expected switches, expected output; load and no soft reset
  localparam logic [18:0] ROWS [17] = '{
    {8'h80, 10'h2AA, 1'b0}, {8'h0E, 10'h0AA, 1'b0}, {8'h8F, 10'h02A, 1'b0},
    {8'h90, 10'h00A, 1'b0}, {8'h11, 10'h002, 1'b0}, {8'h12, 10'h000, 1'b0},
    {8'h81, 10'h155, 1'b0}, {8'h01, 10'h000, 1'b0}, {8'h94, 10'h000, 1'b1},
    {8'h0C, 10'h000, 1'b1}, {8'h8D, 10'h000, 1'b1}, {8'h13, 10'h000, 1'b1},
    {8'h93, 10'h000, 1'b1}, {8'h9F, 10'h000, 1'b1}, {8'h80, 10'h2AA, 1'b1},
    {8'h1F, 10'h000, 1'b1}, {8'h14, 10'h000, 1'b0}};
  mxs_switch_slave i_mxs_switch_slave (.ref_clk(refClk), .nrst(nrst), .sclIn(sclW),
    .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .addr_strap_0(strap[0]),
    .addr_strap_1(strap[1]), .addr_strap_2(strap[2]), .switchClosed(sw),
    .general_output_pin(gpo));
  mxs_master i_mxs_master (.ref_clk(refClk), .sdaBus(sdaBus), .sclOut(sclW),
    .sdaRel(sdaRel));
  always #5 refClk = ~refClk;
  // Hang guard, well above the expected run of about 20600 cycles
  always @(posedge refClk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [7:0] d, input logic exp);
    i_mxs_master.wbyte(d, ack);
    chk(ack, exp);
  endtask
  // One write word; acks expected only when the address is ours
  task automatic wr(input logic [7:0] c, input logic [7:0] m, input logic [6:0] a);
    logic e;
    e = (a == dev);
    i_mxs_master.start();
    wb({a, 1'b0}, e);
    wb(c, e);
    wb(m, e);
    i_mxs_master.stop();
  endtask
  // Both read bytes against expectation, and the pins themselves
  task automatic rdchk(input logic [9:0] es, input logic eg);
    i_mxs_master.start();
    wb({dev, 1'b1}, 1'b1);
    i_mxs_master.rbyte(1'b0, hi);
    i_mxs_master.rbyte(1'b1, lo);
    i_mxs_master.stop();
    chk({hi, lo}, {es, 2'b00, eg, 3'b000});
    chk({gpo, sw}, {eg, es});
  endtask
  initial begin
    repeat (5) @(posedge refClk);
    chk({gpo, sdaOe_n, sw}, 12'h400);
    repeat (5) @(posedge refClk);
    nrst <= 1'b1;
    repeat (3) @(posedge refClk);
    foreach (ROWS[i]) begin
      wr(ROWS[i][18:11], 8'h03, dev);
      rdchk(ROWS[i][10:1], ROWS[i][0]);
    end
    // Each single switch closed then opened, never two of one mux
    for (int s = 2; s <= 11; s++) begin
      wr({1'b1, 7'(s)}, 8'h03, dev);
      rdchk(10'h001 << (11 - s), 1'b0);
      wr({1'b0, 7'(s)}, 8'h03, dev);
      rdchk(10'h000, 1'b0);
    end
    // Staged pairs in one frame: nothing moves until the load bit
    i_mxs_master.start();
    wb({dev, 1'b0}, 1'b1);
    wb(8'h82, 1'b1);
    wb(8'h01, 1'b1);
    wb(8'h94, 1'b1);
    wb(8'h01, 1'b1);
    chk({gpo, sw}, 11'h000);
    wb(8'h02, 1'b1);
    wb(8'h01, 1'b1);
    wb(8'h84, 1'b1);
    wb(8'h03, 1'b1);
    i_mxs_master.stop();
    rdchk(10'h080, 1'b1);
    // Soft reset opens all and drops what was pending
    wr(8'h8B, 8'h01, dev);
    wr(8'h00, 8'h02, dev);
    rdchk(10'h000, 1'b0);
    wr(8'h0C, 8'h03, dev);
    rdchk(10'h000, 1'b0);
    // Foreign address ignored, then a new strap setting answers
    wr(8'h80, 8'h03, 7'h56);
    rdchk(10'h000, 1'b0);
    strap <= 3'h2;
    @(posedge refClk);
    wr(8'h80, 8'h03, dev);
    rdchk(10'h2AA, 1'b0);
    // Stop inside a command byte abandons it
    i_mxs_master.start();
    wb({dev, 1'b0}, 1'b1);
    repeat (4) i_mxs_master.bitx(1'b0, ack);
    i_mxs_master.stop();
    rdchk(10'h2AA, 1'b0);
    // Reset in mid-run
    nrst <= 1'b0;
    repeat (3) @(posedge refClk);
    chk({gpo, sdaOe_n, sw}, 12'h400);
    nrst <= 1'b1;
    repeat (3) @(posedge refClk);
    rdchk(10'h000, 1'b0);
    end_of_test();
  end
endmodule
